// ---- dsb_assertions.sv ----
`timescale 1ns/10ps
// ==========
// apb answer and read burst checks
module dsb_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] mem_dq_o,
  input wire logic        mem_dq_oe,
  input wire logic        mem_rd_valid
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] vlen_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) vlen_q <= 8'h00;
    else vlen_q <= mem_rd_valid ? vlen_q + 8'h01 : 8'h00;
  end
  a_ready_high: assert property (pready) else $error("pready low");
  a_slverr_map: assert property (psel && penable && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h18))
    else $error("pslverr does not match address map");
  a_slverr_idle: assert property (!penable |-> !pslverr) else $error("pslverr outside access");
  a_err_data: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("read data on refused access");
  a_oe_burst: assert property (mem_dq_oe |-> mem_rd_valid) else $error("dq driven outside burst");
  a_dq_idle: assert property (!mem_rd_valid |-> mem_dq_o == 32'h0) else $error("dq not zero when idle");
  a_dq_steady: assert property (mem_rd_valid && $past(mem_rd_valid) |-> $stable(mem_dq_o))
    else $error("dq moved in burst");
  a_burst_len: assert property ($fell(mem_rd_valid) |-> vlen_q inside {[8'h1F:8'h21]})
    else $error("burst not four link periods");
  a_first_gap: assert property ($rose(mem_rd_valid) |-> $past(mem_rd_valid, 40) == 1'b0)
    else $error("read data too soon");
endmodule // dsb_assertions

bind dsb_ddr3_cfg dsb_assertions u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .mem_dq_o(mem_dq_o), .mem_dq_oe(mem_dq_oe), .mem_rd_valid(mem_rd_valid)
);

// ---- dsb_ctl_model.sv ----
`timescale 1ns/10ps
// ==========
// memory controller: free running link clock and commands
module dsb_ctl_model (
  output logic        mem_ck,
  output logic        mem_cke,
  output logic        mem_cs_n,
  output logic        mem_ras_n,
  output logic        mem_cas_n,
  output logic        mem_we_n,
  output logic [2:0]  mem_ba,
  output logic [12:0] mem_addr
);
  initial begin
    mem_ck = 1'h0;
    mem_cke = 1'h1;
    {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} = 4'hF;
    mem_ba = 3'h0;
    mem_addr = 13'h0000;
    #7;
    forever #160 mem_ck = ~mem_ck;
  end
  // row timing in ps for the faster grade, turned into link cycles by rounding up
  localparam int CK_PS  = 320000;
  localparam int AA_PS  = 13125;
  localparam int RCD_PS = 13125;
  localparam int RP_PS  = 13125;
  localparam int RC_PS  = 48750;
  localparam int RAS_PS = 35000;
  int ck_cnt = 0;
  int act_at [8];
  always @(posedge mem_ck) ck_cnt <= ck_cnt + 1;
  function automatic int cycles(input int ps);
    return (ps + CK_PS - 1) / CK_PS;
  endfunction
  // read latency from the internal read time at a standard period, rounded up
  function automatic int cl_for(input int tck_ps);
    int n;
    n = (AA_PS + tck_ps - 1) / tck_ps;
    return (n < 6) ? 6 : n;
  endfunction
  task automatic set_cke(input logic v);
    mem_cke <= v;
  endtask
  // open a row: row cycle since the last activate of this bank, then activate-to-access
  task automatic activate(input logic [2:0] b);
    while (ck_cnt - act_at[b] < cycles(RC_PS)) @(posedge mem_ck);
    cmd(4'h3, b, 13'h0000);
    act_at[b] = ck_cnt;
    repeat (cycles(RCD_PS)) @(posedge mem_ck);
  endtask
  // close a row: row active time first, then the precharge period
  task automatic precharge(input logic [2:0] b);
    while (ck_cnt - act_at[b] < cycles(RAS_PS)) @(posedge mem_ck);
    cmd(4'h2, b, 13'h0000);
    repeat (cycles(RP_PS)) @(posedge mem_ck);
  endtask
  // command changes on the falling edge so it is steady at the rising edge
  task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [12:0] a);
    @(negedge mem_ck);
    {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= c;
    mem_ba <= b;
    mem_addr <= a;
    @(negedge mem_ck);
    {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= 4'hF;
    mem_ba <= ~b;
    mem_addr <= ~a;
  endtask
endmodule // dsb_ctl_model

// ---- dsb_ddr3_cfg.sv ----
// Function
// - first read data follows the read after the programmed read latency
// - mode register 0 bits 1:0 equal 00 give fixed burst of eight
// - mode register 0 bit 12 selects slow or fast power-down exit
// - mode register 2 bit 6 enables automatic self-refresh rate
// - mode register 2 bit 7 selects extended self-refresh temperature range
// - mode register 0 bit 3 zero selects nibble-sequential read order
// - mode register 1 bit 12 zero enables outputs, driver field 01
// - termination on by 011 in mode register 1, dynamic by 10 in 2
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/10ps
module dsb_ddr3_cfg #(
  parameter bit FAST_GRADE = 1'b1,
  parameter int BA_W       = 3,
  parameter int ADDR_W     = 13
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              mem_ck,
  input  wire logic              mem_cke,
  input  wire logic              mem_cs_n,
  input  wire logic              mem_ras_n,
  input  wire logic              mem_cas_n,
  input  wire logic              mem_we_n,
  input  wire logic [BA_W-1:0]   mem_ba,
  input  wire logic [ADDR_W-1:0] mem_addr,
  output logic      [31:0]       mem_dq_o,
  output logic                   mem_dq_oe,
  output logic                   mem_rd_valid,
  output logic                   mem_odt_en
);

  localparam int SW = ADDR_W + BA_W + 6;

  // ==========================================================
  // pin synchronisers
  logic [SW-1:0] pins_s;
  logic          ck_s, ck_d1_q, ck_rise;
  logic          cke_s;
  logic [3:0]    cmd_s;
  logic [BA_W-1:0]   ba_s;
  logic [ADDR_W-1:0] addr_s;

  dsb_sync #(.W(SW)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .async_i ({mem_ck, mem_cke, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_ba, mem_addr}),
    .sync_o  (pins_s)
  );

  assign {ck_s, cke_s, cmd_s, ba_s, addr_s} = pins_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_d1_q <= 1'b0;
    end else if (ce) begin
      ck_d1_q <= ck_s;
    end
  end

  assign ck_rise = ck_s & ~ck_d1_q;

  // ==========================================================
  // registers
  logic [1:0]  ctrl_q;
  logic [12:0] mr0_q, mr1_q, mr2_q;
  logic [31:0] rdata_q;
  logic        err_q;
  logic        cmd_valid;
  logic        mrs_hit, read_hit;
  logic        wr_acc, rd_setup;
  logic        addr_ok;
  logic [31:0] rd_mux;
  logic [31:0] status;

  assign cmd_valid = ck_rise & cke_s & ctrl_q[dsb_pkg::CTRL_EN_BIT];
  assign mrs_hit   = cmd_valid && (cmd_s == dsb_pkg::CMD_MRS);
  assign read_hit  = cmd_valid && (cmd_s == dsb_pkg::CMD_READ);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mr0_q <= dsb_pkg::MR_RST;
      mr1_q <= dsb_pkg::MR_RST;
      mr2_q <= dsb_pkg::MR_RST;
    end else if (ce && mrs_hit) begin
      case (ba_s[1:0])
        2'h0:    mr0_q <= addr_s[12:0];
        2'h1:    mr1_q <= addr_s[12:0];
        2'h2:    mr2_q <= addr_s[12:0];
        default: mr0_q <= mr0_q;
      endcase
    end
  end

  // ==========================================================
  // mode decode
  logic [3:0] cl, cwl;
  logic       bl8, fast_exit, asr_on, srt_ext, seq_order;
  logic       outbuf_on, drv_ok, rtt_nom_on, rtt_wr_on, reserved;
  logic       pair_ok;

  assign cl  = dsb_pkg::CL_BASE + {1'b0, mr0_q[dsb_pkg::MR0_CL_LO +: 3]};
  assign cwl = dsb_pkg::CWL_BASE + {1'b0, mr2_q[dsb_pkg::MR2_CWL_LO +: 3]};

  assign bl8        = (mr0_q[dsb_pkg::MR0_BL_LO +: 2] == dsb_pkg::BL_FIXED8);
  assign fast_exit  = mr0_q[dsb_pkg::MR0_PPD_BIT];
  assign asr_on     = mr2_q[dsb_pkg::MR2_ASR_BIT];
  assign srt_ext    = mr2_q[dsb_pkg::MR2_SRT_BIT];
  assign seq_order  = ~mr0_q[dsb_pkg::MR0_ORD_BIT];
  assign outbuf_on  = ~mr1_q[dsb_pkg::MR1_QOFF_BIT];
  assign drv_ok     = ({mr1_q[dsb_pkg::MR1_DRV_B], mr1_q[dsb_pkg::MR1_DRV_A]} == dsb_pkg::DRV_SEL);
  assign rtt_nom_on = ({mr1_q[dsb_pkg::MR1_RTT_C], mr1_q[dsb_pkg::MR1_RTT_B],
                        mr1_q[dsb_pkg::MR1_RTT_A]} == dsb_pkg::RTT_NOM_ON);
  assign rtt_wr_on  = (mr2_q[dsb_pkg::MR2_RTTW_LO +: 2] == dsb_pkg::RTT_WR_ON);

  // latency pair must match a supported speed bin
  always_comb begin
    case (cl)
      4'h6:    pair_ok = (cwl == 4'h5);
      4'h7,
      4'h8:    pair_ok = (cwl == 4'h6);
      4'h9,
      4'hA:    pair_ok = (cwl == 4'h7);
      4'hB:    pair_ok = (cwl == 4'h8) && FAST_GRADE;
      default: pair_ok = 1'b0;
    endcase
  end

  // flag encodings the grade cannot run
  assign reserved = mr0_q[dsb_pkg::MR0_CL_LOW] || (cl < dsb_pkg::CL_MIN)
                  || (cl > (FAST_GRADE ? dsb_pkg::CL_MAX_F : dsb_pkg::CL_MAX_S))
                  || (cwl > (FAST_GRADE ? dsb_pkg::CWL_MAX_F : dsb_pkg::CWL_MAX_S))
                  || !pair_ok;

  // ==========================================================
  // apb slave, zero wait states
  assign pready   = 1'b1;
  assign wr_acc   = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;

  always_comb begin
    case (paddr)
      dsb_pkg::OFF_CTRL, dsb_pkg::OFF_STATUS, dsb_pkg::OFF_MR0, dsb_pkg::OFF_MR1,
      dsb_pkg::OFF_MR2, dsb_pkg::OFF_RDATA, dsb_pkg::OFF_ERR: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  assign pslverr = psel & penable & ~addr_ok;

  assign status = {13'h0000, cwl, cl, reserved, rtt_wr_on, rtt_nom_on, drv_ok, outbuf_on,
                   seq_order, srt_ext, asr_on, fast_exit, bl8, ~cke_s};

  always_comb begin
    case (paddr)
      dsb_pkg::OFF_CTRL:   rd_mux = {30'h0, ctrl_q};
      dsb_pkg::OFF_STATUS: rd_mux = status;
      dsb_pkg::OFF_MR0:    rd_mux = {19'h0, mr0_q};
      dsb_pkg::OFF_MR1:    rd_mux = {19'h0, mr1_q};
      dsb_pkg::OFF_MR2:    rd_mux = {19'h0, mr2_q};
      dsb_pkg::OFF_RDATA:  rd_mux = rdata_q;
      dsb_pkg::OFF_ERR:    rd_mux = {31'h0, err_q};
      default:             rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (ce && rd_setup) begin
      prdata <= rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= dsb_pkg::CTRL_RST;
      rdata_q <= dsb_pkg::RDATA_RST;
    end else if (ce && wr_acc) begin
      if (paddr == dsb_pkg::OFF_CTRL) begin
        ctrl_q <= pwdata[1:0];
      end
      if (paddr == dsb_pkg::OFF_RDATA) begin
        rdata_q <= pwdata;
      end
    end
  end

  // sticky reserved-encoding flag, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= 1'b0;
    end else if (ce) begin
      if (reserved && ctrl_q[dsb_pkg::CTRL_EN_BIT]) begin
        err_q <= 1'b1;
      end else if (wr_acc && (paddr == dsb_pkg::OFF_ERR) && pwdata[0]) begin
        err_q <= 1'b0;
      end
    end
  end

  // termination follows mode setting and software enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_odt_en <= 1'b0;
    end else if (ce) begin
      mem_odt_en <= ctrl_q[dsb_pkg::CTRL_ODT_BIT] & (rtt_nom_on | rtt_wr_on);
    end
  end

  // ==========================================================
  // read latency and burst
  dsb_pkg::dsb_state_t state_q;
  logic [3:0] lat_q;
  logic [2:0] beat_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= dsb_pkg::DSB_IDLE;
      lat_q   <= 4'h0;
      beat_q  <= 3'h0;
    end else if (ce) begin
      case (state_q)
        dsb_pkg::DSB_IDLE: begin
          if (read_hit && !reserved) begin
            state_q <= dsb_pkg::DSB_LAT;
            // count a full read latency of link edges before the first word
            lat_q   <= cl;
          end
        end
        dsb_pkg::DSB_LAT: begin
          if (ck_rise) begin
            if (lat_q == 4'h1) begin
              state_q <= dsb_pkg::DSB_BURST;
              beat_q  <= dsb_pkg::BEATS_BL8;
            end else begin
              lat_q <= lat_q - 4'h1;
            end
          end
        end
        dsb_pkg::DSB_BURST: begin
          if (ck_rise) begin
            if (beat_q == 3'h1) begin
              state_q <= dsb_pkg::DSB_IDLE;
            end
            beat_q <= beat_q - 3'h1;
          end
        end
        default: state_q <= dsb_pkg::DSB_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_rd_valid <= 1'b0;
      mem_dq_oe    <= 1'b0;
      mem_dq_o     <= 32'h00000000;
    end else if (ce) begin
      mem_rd_valid <= (state_q == dsb_pkg::DSB_BURST);
      mem_dq_oe    <= (state_q == dsb_pkg::DSB_BURST) && outbuf_on;
      mem_dq_o     <= (state_q == dsb_pkg::DSB_BURST) ? rdata_q : 32'h00000000;
    end
  end

endmodule // dsb_ddr3_cfg

// ---- dsb_pkg.sv ----
package dsb_pkg;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_MR0    = 8'h08;
  localparam logic [7:0] OFF_MR1    = 8'h0C;
  localparam logic [7:0] OFF_MR2    = 8'h10;
  localparam logic [7:0] OFF_RDATA  = 8'h14;
  localparam logic [7:0] OFF_ERR    = 8'h18;

  // ==========================================================
  // reset values
  localparam logic [1:0]  CTRL_RST  = 2'h0;
  localparam logic [12:0] MR_RST    = 13'h0000;
  localparam logic [31:0] RDATA_RST = 32'h00000000;

  // ==========================================================
  // control bits
  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_ODT_BIT = 1;

  // ==========================================================
  // mode register field positions
  localparam int MR0_BL_LO    = 0;
  localparam int MR0_CL_LOW   = 2;
  localparam int MR0_ORD_BIT  = 3;
  localparam int MR0_CL_LO    = 4;
  localparam int MR0_PPD_BIT  = 12;
  localparam int MR1_DRV_A    = 1;
  localparam int MR1_RTT_A    = 2;
  localparam int MR1_DRV_B    = 5;
  localparam int MR1_RTT_B    = 6;
  localparam int MR1_RTT_C    = 9;
  localparam int MR1_QOFF_BIT = 12;
  localparam int MR2_CWL_LO   = 3;
  localparam int MR2_ASR_BIT  = 6;
  localparam int MR2_SRT_BIT  = 7;
  localparam int MR2_RTTW_LO  = 9;

  // ==========================================================
  // encodings
  localparam logic [1:0] BL_FIXED8  = 2'h0;
  localparam logic [1:0] DRV_SEL    = 2'h1;
  localparam logic [2:0] RTT_NOM_ON = 3'h3;
  localparam logic [1:0] RTT_WR_ON  = 2'h2;
  localparam logic [3:0] CL_BASE    = 4'h4;
  localparam logic [3:0] CWL_BASE   = 4'h5;
  localparam logic [3:0] CL_MIN     = 4'h6;
  localparam logic [3:0] CL_MAX_F   = 4'hB;
  localparam logic [3:0] CL_MAX_S   = 4'hA;
  localparam logic [3:0] CWL_MAX_F  = 4'h8;
  localparam logic [3:0] CWL_MAX_S  = 4'h7;
  localparam logic [2:0] BEATS_BL8  = 3'h4;

  // command code {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_MRS  = 4'h0;
  localparam logic [3:0] CMD_READ = 4'h5;

  typedef enum logic [2:0] {
    DSB_IDLE  = 3'b001,
    DSB_LAT   = 3'b010,
    DSB_BURST = 3'b100
  } dsb_state_t;

endpackage

// ---- dsb_sync.sv ----
`timescale 1ns/10ps
module dsb_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_q;

  // ==========================================================
  // two-flop synchroniser per bit
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_q[i] <= 1'b0;
          sync_o[i] <= 1'b0;
        end else if (ce) begin
          meta_q[i] <= async_i[i];
          sync_o[i] <= meta_q[i];
        end
      end
    end
  endgenerate

endmodule // dsb_sync

// ---- tb.sv ----
`timescale 1ns/10ps
module tb;
  logic        pclk = 1'h0, presetn = 1'h0, ce = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, mem_dq_o, rd;
  logic        pready, pslverr, mem_ck, mem_cke, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n;
  logic        mem_dq_oe, mem_rd_valid, mem_odt_en, er;
  logic [2:0]  mem_ba;
  logic [12:0] mem_addr;
  logic [11:0] tab [9] = '{12'h650, 12'h760, 12'h860, 12'h970, 12'hA70, 12'hB80, 12'hB71, 12'h661, 12'h551};
  int          err_count = 0, n_tests = 0, cyc = 0, ck_n = 0, rises = 0;
  always #20 pclk = ~pclk;
  always @(posedge mem_ck) ck_n++;
  always @(posedge mem_rd_valid) rises++;
  dsb_ctl_model u_ctl (.mem_ck(mem_ck), .mem_cke(mem_cke), .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n),
    .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n), .mem_ba(mem_ba), .mem_addr(mem_addr));
  dsb_ddr3_cfg u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_ck(mem_ck),
    .mem_cke(mem_cke), .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n),
    .mem_ba(mem_ba), .mem_addr(mem_addr), .mem_dq_o(mem_dq_o), .mem_dq_oe(mem_dq_oe),
    .mem_rd_valid(mem_rd_valid), .mem_odt_en(mem_odt_en));
  // ==========
  // tasks
  task automatic give_verdict();
    if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  // second read lands in the latency and must be refused
  task automatic burst(input logic [3:0] cl, input logic ok, input logic oe);
    int e0, r0, t;
    r0 = rises;
    u_ctl.activate(3'h0);
    u_ctl.cmd(dsb_pkg::CMD_READ, 3'h0, 13'h0000);
    e0 = ck_n;
    u_ctl.cmd(dsb_pkg::CMD_READ, 3'h0, 13'h0000);
    t = 0;
    while (mem_rd_valid !== 1'h1 && t < 200) begin
      @(negedge pclk);
      t++;
    end
    if (ok) begin
      chk("read latency", {28'h0, cl}, 32'(ck_n - e0));
      chk("dq", 32'hC3A55A3C, mem_dq_o);
      chk("dq_oe", {31'h0, oe}, {31'h0, mem_dq_oe});
      e0 = ck_n;
      while (mem_rd_valid === 1'h1) @(negedge pclk);
      chk("burst length", 32'h4, 32'(ck_n - e0));
    end
    repeat (100) @(negedge pclk);
    u_ctl.precharge(3'h0);
    chk("bursts", {31'h0, ok}, 32'(rises - r0));
  endtask
  // ==========
  // sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    for (int i = 0; i < 7; i++) rchk("reset reg", 8'(i * 4), i == 1 ? {13'h0, 4'h5, 4'h4, 1'h1, 10'h062} : 32'h0);
    rchk("unmapped rd", 8'h1C, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    u_ctl.cmd(dsb_pkg::CMD_MRS, 3'h0, 13'h1020);
    rchk("mr0 decode off", dsb_pkg::OFF_MR0, 32'h0);
    apb(1'h1, dsb_pkg::OFF_RDATA, 32'hC3A55A3C);
    ce <= 1'h0;
    apb(1'h1, dsb_pkg::OFF_RDATA, 32'h0);
    ce <= 1'h1;
    rchk("rdata", dsb_pkg::OFF_RDATA, 32'hC3A55A3C);
    apb(1'h1, dsb_pkg::OFF_CTRL, 32'h3);
    rchk("ctrl", dsb_pkg::OFF_CTRL, 32'h3);
    u_ctl.cmd(dsb_pkg::CMD_MRS, 3'h1, 13'h0046);
    for (int i = 0; i < 9; i++) begin
      u_ctl.cmd(dsb_pkg::CMD_MRS, 3'h0, 13'h1000 | (13'(tab[i][11:8] - 4'h4) << 4));
      u_ctl.cmd(dsb_pkg::CMD_MRS, 3'h2, 13'h04C0 | (13'(tab[i][7:4] - 4'h5) << 3));
      rchk("status", dsb_pkg::OFF_STATUS, {13'h0, tab[i][7:4], tab[i][11:8], tab[i][0], 10'h3FE});
      apb(1'h1, dsb_pkg::OFF_ERR, 32'h1);
      rchk("err flag", dsb_pkg::OFF_ERR, {31'h0, tab[i][0]});
      burst(tab[i][11:8], !tab[i][0], 1'h1);
    end
    rchk("mr1", dsb_pkg::OFF_MR1, 32'h0046);
    rchk("mr2", dsb_pkg::OFF_MR2, 32'h04C0);
    chk("odt on", 32'h1, {31'h0, mem_odt_en});
    u_ctl.cmd(dsb_pkg::CMD_MRS, 3'h0, 13'h0009 | (13'(u_ctl.cl_for(2500) - 4) << 4));
    u_ctl.cmd(dsb_pkg::CMD_MRS, 3'h1, 13'h1046);
    u_ctl.cmd(dsb_pkg::CMD_MRS, 3'h2, 13'h0000);
    rchk("status alt", dsb_pkg::OFF_STATUS, {13'h0, 4'h5, 4'h6, 1'h0, 10'h180});
    burst(4'h6, 1'h1, 1'h0);
    apb(1'h1, dsb_pkg::OFF_CTRL, 32'h1);
    repeat (2) @(negedge pclk);
    chk("odt off", 32'h0, {31'h0, mem_odt_en});
    u_ctl.set_cke(1'h0);
    repeat (8) @(posedge pclk);
    rchk("status cke", dsb_pkg::OFF_STATUS, {13'h0, 4'h5, 4'h6, 1'h0, 10'h181});
    give_verdict();
  end
endmodule // tb
